// ===== core/rrcs_regs.vh
// register map, field positions and reset values of the reference clock selector
`ifndef RRCS_REGS_VH
`define RRCS_REGS_VH

// word offsets; byte address is four times the offset
`define RRCS_OFF_PLL       3'h0
`define RRCS_OFF_MISC      3'h1
`define RRCS_OFF_PADA_MUX  3'h2
`define RRCS_OFF_PADA_CTL  3'h3
`define RRCS_OFF_PADB_MUX  3'h4
`define RRCS_OFF_PADB_CTL  3'h5
`define RRCS_OFF_SELIN     3'h6
`define RRCS_OFF_STAT      3'h7

// field positions
`define RRCS_MISC_SRC_BIT  21
`define RRCS_FORCE_BIT     4
`define RRCS_SLEW_BIT      0
`define RRCS_DRV_LSB       3
`define RRCS_DRV_MSB       5

// codes
`define RRCS_PLL_50MHZ     2'h1
`define RRCS_MUX_FUNC_TWO  3'h2
`define RRCS_MUX_FUNC_SEV  3'h7
`define RRCS_SRC_NONE      2'h0
`define RRCS_SRC_ONCHIP    2'h1
`define RRCS_SRC_EXTERN    2'h2

// reset values
`define RRCS_RST_PLL       2'h0
`define RRCS_RST_MUX       3'h5
`define RRCS_RST_DRV       3'h6
`define RRCS_RST_WORD      32'h0000_0000

`endif

// ===== core/rrcs_sync2.v
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module rrcs_sync2 #(
    parameter WIDTH = 3
) (
    input  wire             mclk_i,   // system clock
    input  wire             nrst_i,   // sync reset, active low
    input  wire [WIDTH-1:0] async_i,  // levels from pins
    output reg  [WIDTH-1:0] sync_o    // synchronised levels
);

    reg [WIDTH-1:0] meta;

    // first stage read only by the second
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            meta   <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== core/rrcs_pll_div.v
// ethernet pll model: a toggling reference from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "rrcs_regs.vh"

module rrcs_pll_div (
    input  wire       mclk_i,    // system clock
    input  wire       nrst_i,    // sync reset, active low
    input  wire [1:0] freq_i,    // frequency field
    output reg        ref_o,     // generated reference level
    output reg        is_50_o    // field holds the 50 mhz code
);

    reg [2:0] div;
    reg [2:0] lim;

    // 01 toggles every cycle and stands for 50 mhz
    always @* begin
        case (freq_i)
            `RRCS_PLL_50MHZ: lim = 3'h0;
            2'h0:            lim = 3'h1;
            2'h2:            lim = 3'h3;
            default:         lim = 3'h7;
        endcase
    end

    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            div     <= 3'h0;
            ref_o   <= 1'b0;
            is_50_o <= 1'b0;
        end else begin
            is_50_o <= (freq_i == `RRCS_PLL_50MHZ);
            if (div >= lim) begin
                div   <= 3'h0;
                ref_o <= ~ref_o;
            end else begin
                div <= div + 3'h1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== core/rrcs_top.v
// rmii reference clock selector with avalon-mm register slave
//
// Behaviour
// - frequency field value 01 makes the ethernet pll give the 50 mhz reference.
// - preferred pad carries the reference clock when its mux holds 010.
// - source bit 21 set takes the reference from the pll, looped through the pad and driven out.
// - source bit 21 clear takes the reference from the pad input, fed externally.
// - on the first variant, input select 1 routes the preferred pad and 0 the alternate.
// - on the second variant, input select 0 routes the preferred pad and 1 the alternate.
// - the alternate pad carries the reference when its mux holds function seven.
// - alternate pad control has no slew bit; its drive strength sits in bits 5 to 3.
// - the full mii reference pin is ignored in rmii mode.
// - the mac reference comes from at most one of on-chip, oscillator or phy; none while the routed pad's mux is not set.
// - the reference always enters the mac through the pad input path.
`timescale 1ns/1ps
`default_nettype none
`include "rrcs_regs.vh"

module rrcs_top #(
    parameter VARIANT  = 0,   // 0 first variant, 1 second variant
    parameter ACT_WIN  = 16   // cycles without an edge before clock is lost
) (
    input  wire        mclk_i,              // 40 mhz system clock
    input  wire        nrst_i,              // sync reset, active low
    input  wire [2:0]  avs_address_i,       // word address
    input  wire        avs_read_i,          // read strobe
    input  wire        avs_write_i,         // write strobe
    input  wire [31:0] avs_writedata_i,     // write data
    input  wire [3:0]  avs_byteenable_i,    // byte lanes
    output reg  [31:0] avs_readdata_o,      // read data
    output reg         avs_waitrequest_o,   // stall, low marks answer
    input  wire        pref_pad_i,          // preferred pad level in
    output reg         pref_pad_o,          // preferred pad level out
    output reg         pref_pad_oe_o,       // preferred pad drive enable
    input  wire        alternate_clock_pad_i,     // alternate pad in
    output reg         alternate_clock_pad_o,     // alternate pad out
    output reg         alternate_clock_pad_oe_o,  // alternate pad enable
    input  wire        mii_ref_clock_pin_i, // full mii pin, unused
    output reg         pref_slew_o,         // preferred pad fast slew
    output reg  [2:0]  alt_drive_o,         // alternate pad drive strength
    output reg         mac_ref_clk_o,       // reference level to the mac
    output reg         mac_ref_rise_o,      // one pulse per reference rise
    output reg  [1:0]  mac_src_o            // active source code
);

    // registers
    reg  [1:0]  ethernet_pll_control;
    reg  [31:0] soc_misc_control_word;
    reg  [2:0]  pref_mux;
    reg         pref_force_input_path;
    reg         pref_slew_rate_field;
    reg  [2:0]  alt_mux;
    reg         alt_force_input_path;
    reg  [2:0]  alt_drive_strength_field;
    reg         ref_clock_input_select_reg;

    // internal state
    reg  [31:0] rdata;
    reg  [31:0] wmask;
    reg  [31:0] next_misc;
    reg  [7:0]  act_cnt;
    reg         clk_present;
    reg         mac_ref_d;
    reg         next_ref;
    reg  [1:0]  next_src;
    reg         fault;

    wire        pll_ref;
    wire        pll_is_50;
    wire [1:0]  pads_sync;
    wire        acc;
    wire        wr;
    wire        src_onchip;
    wire        pref_active;
    wire        alt_active;
    wire        route_pref;

    // pll model
    rrcs_pll_div u_pll (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .freq_i  (ethernet_pll_control),
        .ref_o   (pll_ref),
        .is_50_o (pll_is_50)
    );

    // pad inputs cross into the system clock; mii pin not sampled
    rrcs_sync2 #(
        .WIDTH (2)
    ) u_sync (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .async_i ({alternate_clock_pad_i, pref_pad_i}),
        .sync_o  (pads_sync)
    );

    // bus request accepted while waitrequest is still high
    assign acc = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    assign wr  = acc & avs_write_i;

    assign src_onchip  = soc_misc_control_word[`RRCS_MISC_SRC_BIT];
    assign pref_active = (pref_mux == `RRCS_MUX_FUNC_TWO);
    assign alt_active  = (alt_mux == `RRCS_MUX_FUNC_SEV);

    // input select polarity differs per variant
    assign route_pref = (VARIANT == 0) ? ref_clock_input_select_reg
                                       : ~ref_clock_input_select_reg;

    // byte lane mask
    always @* begin
        wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                 {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
        next_misc = (soc_misc_control_word & ~wmask) | (avs_writedata_i & wmask);
    end

    // read mux, unmapped words read zero
    always @* begin
        rdata = `RRCS_RST_WORD;
        case (avs_address_i)
            `RRCS_OFF_PLL: begin
                rdata[1:0] = ethernet_pll_control;
            end
            `RRCS_OFF_MISC: begin
                rdata = soc_misc_control_word;
            end
            `RRCS_OFF_PADA_MUX: begin
                rdata[2:0]              = pref_mux;
                rdata[`RRCS_FORCE_BIT]  = pref_force_input_path;
            end
            `RRCS_OFF_PADA_CTL: begin
                rdata[`RRCS_SLEW_BIT]   = pref_slew_rate_field;
            end
            `RRCS_OFF_PADB_MUX: begin
                rdata[2:0]              = alt_mux;
                rdata[`RRCS_FORCE_BIT]  = alt_force_input_path;
            end
            `RRCS_OFF_PADB_CTL: begin
                // no slew bit here
                rdata[`RRCS_DRV_MSB:`RRCS_DRV_LSB] = alt_drive_strength_field;
            end
            `RRCS_OFF_SELIN: begin
                rdata[0] = ref_clock_input_select_reg;
            end
            `RRCS_OFF_STAT: begin
                rdata[0]   = src_onchip;
                rdata[1]   = route_pref;
                rdata[2]   = pref_active;
                rdata[3]   = alt_active;
                rdata[4]   = clk_present;
                rdata[5]   = mac_ref_clk_o;
                rdata[6]   = fault;
                rdata[7]   = pll_is_50;
                rdata[9:8] = mac_src_o;
            end
            default: begin
                rdata = `RRCS_RST_WORD;
            end
        endcase
    end

    // avalon slave: one wait cycle, answer with waitrequest low for one cycle
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= `RRCS_RST_WORD;
        end else if (!avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b1;
        end else if (acc) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= avs_read_i ? rdata : `RRCS_RST_WORD;
        end
    end

    // register writes; the force-input bits are stored only
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            ethernet_pll_control       <= `RRCS_RST_PLL;
            soc_misc_control_word      <= `RRCS_RST_WORD;
            pref_mux                   <= `RRCS_RST_MUX;
            pref_force_input_path      <= 1'b0;
            pref_slew_rate_field       <= 1'b0;
            alt_mux                    <= `RRCS_RST_MUX;
            alt_force_input_path       <= 1'b0;
            alt_drive_strength_field   <= `RRCS_RST_DRV;
            ref_clock_input_select_reg <= 1'b0;
        end else if (wr) begin
            case (avs_address_i)
                `RRCS_OFF_PLL: begin
                    if (avs_byteenable_i[0])
                        ethernet_pll_control <= avs_writedata_i[1:0];
                end
                `RRCS_OFF_MISC: begin
                    soc_misc_control_word <= next_misc;
                end
                `RRCS_OFF_PADA_MUX: begin
                    if (avs_byteenable_i[0]) begin
                        pref_mux              <= avs_writedata_i[2:0];
                        pref_force_input_path <= avs_writedata_i[`RRCS_FORCE_BIT];
                    end
                end
                `RRCS_OFF_PADA_CTL: begin
                    if (avs_byteenable_i[0])
                        pref_slew_rate_field <= avs_writedata_i[`RRCS_SLEW_BIT];
                end
                `RRCS_OFF_PADB_MUX: begin
                    if (avs_byteenable_i[0]) begin
                        alt_mux              <= avs_writedata_i[2:0];
                        alt_force_input_path <= avs_writedata_i[`RRCS_FORCE_BIT];
                    end
                end
                `RRCS_OFF_PADB_CTL: begin
                    if (avs_byteenable_i[0])
                        alt_drive_strength_field <=
                            avs_writedata_i[`RRCS_DRV_MSB:`RRCS_DRV_LSB];
                end
                `RRCS_OFF_SELIN: begin
                    if (avs_byteenable_i[0])
                        ref_clock_input_select_reg <= avs_writedata_i[0];
                end
                default: begin
                    soc_misc_control_word <= soc_misc_control_word;
                end
            endcase
        end
    end

    // pad electrical settings
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            pref_slew_o <= 1'b0;
            alt_drive_o <= `RRCS_RST_DRV;
        end else begin
            pref_slew_o <= pref_slew_rate_field;
            alt_drive_o <= alt_drive_strength_field;
        end
    end

    // pad drivers: on-chip source drives the pll clock out on each pad whose mux is active
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            pref_pad_o               <= 1'b0;
            pref_pad_oe_o            <= 1'b0;
            alternate_clock_pad_o    <= 1'b0;
            alternate_clock_pad_oe_o <= 1'b0;
        end else begin
            pref_pad_o               <= pll_ref;
            pref_pad_oe_o            <= src_onchip & pref_active;
            alternate_clock_pad_o    <= pll_ref;
            alternate_clock_pad_oe_o <= src_onchip & alt_active;
        end
    end

    // mac reference taken from the pad input path in both modes
    always @* begin
        next_ref = 1'b0;
        next_src = `RRCS_SRC_NONE;
        fault    = 1'b0;
        if (route_pref) begin
            next_ref = pref_active & pads_sync[0];
            fault    = ~pref_active;
        end else begin
            next_ref = alt_active & pads_sync[1];
            fault    = ~alt_active;
        end
        // one source only: pll looped back, or external pad feed
        if (!fault) begin
            if (src_onchip)
                next_src = `RRCS_SRC_ONCHIP;
            else
                next_src = `RRCS_SRC_EXTERN;
        end
    end

    // mac reference outputs and edge pulse
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            mac_ref_clk_o  <= 1'b0;
            mac_ref_d      <= 1'b0;
            mac_ref_rise_o <= 1'b0;
            mac_src_o      <= `RRCS_SRC_NONE;
        end else begin
            mac_ref_clk_o  <= next_ref;
            mac_ref_d      <= mac_ref_clk_o;
            mac_ref_rise_o <= mac_ref_clk_o & ~mac_ref_d;
            mac_src_o      <= next_src;
        end
    end

    // activity monitor: clock present while edges keep arriving
    always @(posedge mclk_i) begin
        if (!nrst_i) begin
            act_cnt     <= 8'h00;
            clk_present <= 1'b0;
        end else if (mac_ref_clk_o != mac_ref_d) begin
            act_cnt     <= 8'h00;
            clk_present <= 1'b1;
        end else if (act_cnt >= ACT_WIN[7:0]) begin
            clk_present <= 1'b0;
        end else begin
            act_cnt <= act_cnt + 8'h01;
        end
    end

endmodule

`default_nettype wire

// ===== test/rrcs_top_assertions.sv
// port checks for the reference clock selector, bound into every instance
`timescale 1ns/1ps
`default_nettype none
`include "rrcs_regs.vh"

module rrcs_chk #(
    parameter VARIANT = 0,  // select polarity
    parameter ACT_WIN = 16  // clock loss window
) (
    input wire logic       mclk_i,                   // system clock
    input wire logic       nrst_i,                   // sync reset, active low
    input wire logic       avs_read_i,               // read strobe
    input wire logic       avs_write_i,              // write strobe
    input wire logic       avs_waitrequest_o,        // stall
    input wire logic       pref_pad_oe_o,            // preferred pad enable
    input wire logic       alternate_clock_pad_oe_o, // alternate pad enable
    input wire logic       pref_slew_o,              // slew copy
    input wire logic [2:0] alt_drive_o,              // drive copy
    input wire logic       mac_ref_clk_o,            // mac reference
    input wire logic       mac_ref_rise_o,           // rise pulse
    input wire logic [1:0] mac_src_o                 // source code
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    wire drv_any = pref_pad_oe_o | alternate_clock_pad_oe_o;
    sequence s_take; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
    sequence s_answer; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
    sequence s_idle; !avs_read_i && !avs_write_i && avs_waitrequest_o; endsequence
    a_wait_answer: assert property (s_take |=> s_answer) else $error("bus answer not one cycle after take");
    a_wait_idle: assert property (s_idle |=> avs_waitrequest_o) else $error("answer without request");
    a_src_legal: assert property (mac_src_o != 2'h3) else $error("illegal source code");
    a_drive_not_ext: assert property (drv_any [*6] |-> mac_src_o != `RRCS_SRC_EXTERN)
        else $error("pad driven while external source");
    a_onchip_drives: assert property (mac_src_o == `RRCS_SRC_ONCHIP [*6] |-> drv_any)
        else $error("on-chip source without pad drive");
    a_rise_pulse: assert property ($rose(mac_ref_clk_o) |=> mac_ref_rise_o)
        else $error("missing rise pulse");
    a_rise_single: assert property (mac_ref_rise_o |-> $past(mac_ref_clk_o) && !$past(mac_ref_clk_o, 2))
        else $error("rise pulse without rise");
    a_fault_quiet: assert property (mac_src_o == `RRCS_SRC_NONE [*4] |-> !mac_ref_clk_o)
        else $error("reference runs without source");
    a_reset_outs: assert property ($rose(nrst_i) |-> alt_drive_o == `RRCS_RST_DRV && !pref_slew_o
        && !drv_any && avs_waitrequest_o && mac_src_o == 2'h0) else $error("bad outputs after reset");
endmodule

bind rrcs_top rrcs_chk #(.VARIANT(VARIANT), .ACT_WIN(ACT_WIN)) u_chk (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .pref_pad_oe_o(pref_pad_oe_o),
    .alternate_clock_pad_oe_o(alternate_clock_pad_oe_o), .pref_slew_o(pref_slew_o),
    .alt_drive_o(alt_drive_o), .mac_ref_clk_o(mac_ref_clk_o), .mac_ref_rise_o(mac_ref_rise_o),
    .mac_src_o(mac_src_o));
`default_nettype wire

// ===== test/rrcs_phy_model.sv
// phy or oscillator on the two clock pads, with the pad wire levels
`timescale 1ns/1ps
`default_nettype none

module rrcs_phy_model (
    input  wire logic osc_en_i,   // oscillator fitted and running
    input  wire logic pref_o_i,   // preferred pad out
    input  wire logic pref_oe_i,  // preferred pad enable
    input  wire logic alt_o_i,    // alternate pad out
    input  wire logic alt_oe_i,   // alternate pad enable
    output wire logic pref_lvl_o, // preferred pad wire
    output wire logic alt_lvl_o   // alternate pad wire
);
    logic osc = 1'b0;
    logic noise = 1'b0;
    // free running 5 mhz board clock, phase unrelated to the system clock
    initial begin
        #37;
        forever #100 osc = ~osc;
    end
    // released pad shows a changing level, never a held one
    initial forever #13 noise = ~noise;
    assign pref_lvl_o = pref_oe_i ? pref_o_i : (osc_en_i ? osc : noise);
    assign alt_lvl_o  = alt_oe_i ? alt_o_i : (osc_en_i ? osc : noise);
endmodule
`default_nettype wire

// ===== test/test_rrcs_top.sv
// bench for both select polarities of the reference clock selector
`timescale 1ns/1ps
`default_nettype none

module test_rrcs_top;
    logic        mclk_i;
    logic        nrst_i;
    logic [2:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        mii;
    logic        osc_en;
    wire  [31:0] rdata [2];
    wire  [2:0]  drv [2];
    wire  [1:0]  src [2];
    wire  [1:0]  wreq, pref_o, pref_oe, alt_o, alt_oe, pref_lvl, alt_lvl, slew, mref, rise;
    logic [31:0] got [2];
    logic [7:0]  cnt [2];
    int          err_count;
    int          checked;
    localparam logic [31:0] RST_V [7] = '{32'h0, 32'h0, 32'h5, 32'h0, 32'h5, 32'h30, 32'h0};
    localparam logic [31:0] ONE_V [7] = '{32'h3, 32'hFFFFFFFF, 32'h17, 32'h1, 32'h17, 32'h38, 32'h1};

    for (genvar v = 0; v < 2; v++) begin : g_dut
        rrcs_top #(.VARIANT(v), .ACT_WIN(8)) u_dut (
            .mclk_i(mclk_i), .nrst_i(nrst_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
            .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata[v]),
            .avs_waitrequest_o(wreq[v]), .pref_pad_i(pref_lvl[v]), .pref_pad_o(pref_o[v]),
            .pref_pad_oe_o(pref_oe[v]), .alternate_clock_pad_i(alt_lvl[v]), .alternate_clock_pad_o(alt_o[v]),
            .alternate_clock_pad_oe_o(alt_oe[v]), .mii_ref_clock_pin_i(mii), .pref_slew_o(slew[v]),
            .alt_drive_o(drv[v]), .mac_ref_clk_o(mref[v]), .mac_ref_rise_o(rise[v]), .mac_src_o(src[v]));
        rrcs_phy_model u_phy (
            .osc_en_i(osc_en), .pref_o_i(pref_o[v]), .pref_oe_i(pref_oe[v]), .alt_o_i(alt_o[v]),
            .alt_oe_i(alt_oe[v]), .pref_lvl_o(pref_lvl[v]), .alt_lvl_o(alt_lvl[v]));
    end

    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    // full mii pin kept busy to prove it is not used
    always @(posedge mclk_i) mii <= ~mii;

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e, input string m);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t %s got %0d want %0d", $time, m, g, e);
        end
    endtask

    task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        be <= b;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wreq[0] !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("FAIL %0t bus answer timed out", $time);
        end
        cmp_pin({7'h0, wreq[1]}, 8'h0, "second slave answer");
        got[0] = rdata[0];
        got[1] = rdata[1];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    // configure both slaves alike, then judge routing, drive, source and clock rate per polarity
    task automatic cfg(input logic [2:0] pm, input logic [2:0] am, input logic onc, input logic sel);
        logic rp;
        logic ok;
        logic [1:0] es;
        bus(1'b1, 3'h0, 32'h1, 4'hF);
        bus(1'b1, 3'h1, onc ? 32'h0020_0000 : 32'h0, 4'hF);
        bus(1'b1, 3'h2, {27'h0, 1'b1, 1'b0, pm}, 4'hF);
        bus(1'b1, 3'h4, {27'h0, 1'b1, 1'b0, am}, 4'hF);
        bus(1'b1, 3'h6, {31'h0, sel}, 4'hF);
        repeat (20) @(posedge mclk_i);
        cnt[0] = 8'h0;
        cnt[1] = 8'h0;
        repeat (80) begin
            @(posedge mclk_i);
            cnt[0] = cnt[0] + {7'h0, rise[0]};
            cnt[1] = cnt[1] + {7'h0, rise[1]};
        end
        bus(1'b0, 3'h7, 32'h0, 4'hF);
        for (int v = 0; v < 2; v++) begin
            rp = sel ^ v[0];
            ok = rp ? (pm == 3'h2) : (am == 3'h7);
            es = !ok ? 2'h0 : (onc ? 2'h1 : 2'h2);
            cmp_pin({7'h0, pref_oe[v]}, {7'h0, onc && pm == 3'h2}, "preferred enable");
            cmp_pin({7'h0, alt_oe[v]}, {7'h0, onc && am == 3'h7}, "alternate enable");
            cmp_pin({6'h0, src[v]}, {6'h0, es}, "mac source");
            cmp_pin(cnt[v], es == 2'h0 ? 8'd0 : (onc ? 8'd40 : 8'd10), "reference rises");
            cmp_word(got[v] & 32'h34F, {22'h0, es, 1'b0, !ok, 2'b0, am == 3'h7, pm == 3'h2, rp, onc},
                     "status");
        end
    endtask

    initial begin
        #200000;
        err_count++;
        final_report();
    end

    initial begin
        nrst_i = 1'b0;
        addr = 3'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'h0;
        mii = 1'b0;
        osc_en = 1'b0;
        err_count = 0;
        checked = 0;
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            bus(1'b0, a[2:0], 32'h0, 4'hF);
            cmp_word(got[0], RST_V[a], "reset value");
            cmp_word(got[1], RST_V[a], "reset value");
            bus(1'b1, a[2:0], 32'hFFFFFFFF, 4'hF);
            bus(1'b0, a[2:0], 32'h0, 4'hF);
            cmp_word(got[0], ONE_V[a], "writable bits");
        end
        cmp_pin({7'h0, slew[0]}, 8'h1, "slew copy");
        cmp_pin({5'h0, drv[1]}, 8'h7, "drive copy");
        bus(1'b1, 3'h1, 32'h0, 4'hB);
        bus(1'b0, 3'h1, 32'h0, 4'hF);
        cmp_word(got[1], 32'h00FF_0000, "byte lanes");
        cfg(3'h2, 3'h5, 1'b1, 1'b1);
        cfg(3'h5, 3'h7, 1'b1, 1'b0);
        cfg(3'h2, 3'h7, 1'b1, 1'b0);
        osc_en <= 1'b1;
        cfg(3'h2, 3'h7, 1'b0, 1'b1);
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, 3'h0, f, 4'hF);
            bus(1'b0, 3'h7, 32'h0, 4'hF);
            cmp_pin({7'h0, got[0][7]}, {7'h0, f == 1}, "pll code");
        end
        final_report();
    end
endmodule
`default_nettype wire
